//--- design/low_power_mode_control.sv
// Power mode controller: run, idle and sleep, with clock gating and wake-up.
// Assumes synchronous inputs on aclk; wait_req is a one-cycle pulse.
//
// The implementer's own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/10ps
module low_power_mode_control #(
  parameter int NB = 8,
  parameter int NP = 8,
  parameter int PRIO_W = 3,
  parameter logic [7:0] SLEEP_OK = 8'hF0
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // CPU and interrupt controller
  input wire logic wait_req,
  input wire logic [PRIO_W-1:0] cpu_prio,
  input wire logic int_req,
  input wire logic [PRIO_W-1:0] int_prio,
  input wire logic int_sleep_src,
  input wire logic dev_reset_req,
  input wire logic watchdog_timeout,
  // Clock and power controls
  output logic cpu_halt,
  output logic sys_clk_en,
  output logic [1:0] clk_src,
  output logic [2:0] cpu_clk_div,
  output logic [NB-1:0] peripheral_bus_clock,
  output logic [NP-1:0] periph_run,
  output logic clock_fail_monitor,
  output logic brownout_reset,
  output logic watchdog,
  output logic irq
);

  // ********************************
  // Registers and state
  // ********************************
  logic [31:0] osc_ctrl_q;
  logic [31:0] pb_ctrl_q;
  logic [NP-1:0] stop_idle_q;
  logic [lpm_pkg::EV_N-1:0] irq_stat_q;
  logic [lpm_pkg::EV_N-1:0] irq_mask_q;
  lpm_pkg::pwr_state_e state_q;
  lpm_pkg::pwr_state_e state_d;
  logic [15:0] wake_cnt_q;
  logic [15:0] wake_load;
  logic [lpm_pkg::EV_N-1:0] ev;
  logic aw_have_q;
  logic w_have_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic wr_go;
  logic [31:0] wmask;
  logic [31:0] rd_word;
  logic rd_hit;
  logic wr_hit;
  logic sleep_select_bit;
  logic wake_high;

  assign sleep_select_bit = osc_ctrl_q[lpm_pkg::SLEEP_SEL_BIT];
  assign wake_high = int_req && (int_prio > cpu_prio);

  // ********************************
  // Mode sequencer
  // ********************************
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      lpm_pkg::ST_RUN: begin
        if (wait_req && !dev_reset_req) begin
          if (sleep_select_bit) begin
            state_d = lpm_pkg::ST_SLEEP;
          end else begin
            state_d = lpm_pkg::ST_IDLE;
          end
        end
      end
      lpm_pkg::ST_SLEEP: begin
        if (dev_reset_req) begin
          state_d = lpm_pkg::ST_RUN;
        end else if (watchdog_timeout) begin
          state_d = lpm_pkg::ST_WAKE;
        end else if (int_req && int_sleep_src) begin
          if (wake_high) begin
            state_d = lpm_pkg::ST_WAKE;
          end else begin
            state_d = lpm_pkg::ST_IDLE;
          end
        end
      end
      lpm_pkg::ST_WAKE: begin
        if (dev_reset_req || wake_cnt_q == 16'h0000) begin
          state_d = lpm_pkg::ST_RUN;
        end
      end
      lpm_pkg::ST_IDLE: begin
        if (dev_reset_req || watchdog_timeout || wake_high) begin
          state_d = lpm_pkg::ST_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= lpm_pkg::ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // The oscillator restart time depends on the source that was running.
  always_comb begin
    unique case (osc_ctrl_q[lpm_pkg::CLK_SRC_LSB +: 2])
      lpm_pkg::SRC_FRC: wake_load = 16'(lpm_pkg::WAKE_FRC_CYC - 1);
      lpm_pkg::SRC_POSC: wake_load = 16'(lpm_pkg::WAKE_POSC_CYC - 1);
      lpm_pkg::SRC_SOSC: wake_load = 16'(lpm_pkg::WAKE_SOSC_CYC - 1);
      lpm_pkg::SRC_SLOW_RC: wake_load = 16'(lpm_pkg::WAKE_SLOW_RC_CYC - 1);
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_cnt_q <= 16'h0000;
    end else if (state_q != lpm_pkg::ST_WAKE && state_d == lpm_pkg::ST_WAKE) begin
      wake_cnt_q <= wake_load;
    end else if (wake_cnt_q != 16'h0000) begin
      wake_cnt_q <= wake_cnt_q - 16'h0001;
    end
  end

  function automatic logic sys_clk_en_next(lpm_pkg::pwr_state_e s);
    sys_clk_en_next = s == lpm_pkg::ST_RUN || s == lpm_pkg::ST_IDLE;
  endfunction

  // ********************************
  // Clock and power outputs
  // ********************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_halt <= 1'b0;
      sys_clk_en <= 1'b1;
      clock_fail_monitor <= 1'b0;
      brownout_reset <= 1'b0;
      watchdog <= 1'b0;
      clk_src <= 2'b00;
      cpu_clk_div <= 3'b000;
    end else begin
      cpu_halt <= state_d != lpm_pkg::ST_RUN;
      sys_clk_en <= state_d == lpm_pkg::ST_RUN || state_d == lpm_pkg::ST_IDLE;
      clock_fail_monitor <= osc_ctrl_q[lpm_pkg::FAIL_MON_BIT] && sys_clk_en_next(state_d);
      brownout_reset <= 1'b1;
      // Mode changes never touch the watchdog, so its count carries on.
      watchdog <= osc_ctrl_q[lpm_pkg::WDOG_EN_BIT];
      clk_src <= osc_ctrl_q[lpm_pkg::CLK_SRC_LSB +: 2];
      cpu_clk_div <= osc_ctrl_q[lpm_pkg::CPU_DIV_LSB +: 3];
    end
  end

  for (genvar i = 0; i < NP; i++) begin : g_periph
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        periph_run[i] <= 1'b1;
      end else begin
        unique case (state_d)
          lpm_pkg::ST_RUN: periph_run[i] <= 1'b1;
          lpm_pkg::ST_IDLE: periph_run[i] <= !stop_idle_q[i];
          lpm_pkg::ST_SLEEP, lpm_pkg::ST_WAKE: periph_run[i] <= SLEEP_OK[i];
        endcase
      end
    end
  end

  // Each bus gets a one-cycle clock enable every 2^div cycles.
  for (genvar b = 0; b < NB; b++) begin : g_bus
    logic [7:0] div_cnt_q;
    logic [7:0] div_mask;
    assign div_mask = (8'h01 << pb_ctrl_q[4*b +: lpm_pkg::PB_DIV_W]) - 8'h01;
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        div_cnt_q <= 8'h00;
        peripheral_bus_clock[b] <= 1'b0;
      end else begin
        div_cnt_q <= div_cnt_q + 8'h01;
        peripheral_bus_clock[b] <= pb_ctrl_q[4*b + lpm_pkg::PB_EN_BIT]
          && sys_clk_en_next(state_d) && (div_cnt_q & div_mask) == 8'h00;
      end
    end
  end

  // ********************************
  // Events and interrupt
  // ********************************
  always_comb begin
    ev = '0;
    ev[lpm_pkg::EV_SLEEP] = state_q != lpm_pkg::ST_SLEEP && state_d == lpm_pkg::ST_SLEEP;
    ev[lpm_pkg::EV_IDLE] = state_q != lpm_pkg::ST_IDLE && state_d == lpm_pkg::ST_IDLE;
    ev[lpm_pkg::EV_RUN] = state_q != lpm_pkg::ST_RUN && state_d == lpm_pkg::ST_RUN;
    ev[lpm_pkg::EV_WDOG] = watchdog_timeout && state_q != lpm_pkg::ST_RUN;
  end

  // A set in the same cycle as a write-one clear wins.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~(wr_go && aw_addr_q == lpm_pkg::IRQ_STAT_OFF
        ? w_data_q[lpm_pkg::EV_N-1:0] & wmask[lpm_pkg::EV_N-1:0] : '0)) | ev;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  // ********************************
  // AXI4-Lite write path
  // ********************************
  assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
  for (genvar k = 0; k < 4; k++) begin : g_mask
    assign wmask[8*k +: 8] = {8{w_strb_q[k]}};
  end
  assign wr_hit = aw_addr_q == lpm_pkg::OSC_CTRL_OFF || aw_addr_q == lpm_pkg::PB_CTRL_OFF
    || aw_addr_q == lpm_pkg::STOP_IDLE_OFF || aw_addr_q == lpm_pkg::MODE_STAT_OFF
    || aw_addr_q == lpm_pkg::IRQ_STAT_OFF || aw_addr_q == lpm_pkg::IRQ_MASK_OFF;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q <= 1'b1;
      aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
      s_axi_awready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      aw_have_q <= 1'b0;
      s_axi_awready <= 1'b1;
    end else begin
      s_axi_awready <= !aw_have_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      w_have_q <= 1'b0;
      s_axi_wready <= 1'b1;
    end else begin
      s_axi_wready <= !w_have_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= lpm_pkg::RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? lpm_pkg::RESP_OKAY : lpm_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_ctrl_q <= lpm_pkg::OSC_CTRL_RST;
      pb_ctrl_q <= lpm_pkg::PB_CTRL_RST;
      stop_idle_q <= lpm_pkg::STOP_IDLE_RST[NP-1:0];
      irq_mask_q <= lpm_pkg::IRQ_MASK_RST;
    end else if (wr_go) begin
      unique case (aw_addr_q)
        lpm_pkg::OSC_CTRL_OFF: osc_ctrl_q <= (osc_ctrl_q & ~wmask) | (w_data_q & wmask & 32'h0000_00FF);
        lpm_pkg::PB_CTRL_OFF: pb_ctrl_q <= (pb_ctrl_q & ~wmask) | (w_data_q & wmask);
        lpm_pkg::STOP_IDLE_OFF: stop_idle_q <= (stop_idle_q & ~wmask[NP-1:0]) | (w_data_q[NP-1:0] & wmask[NP-1:0]);
        lpm_pkg::IRQ_MASK_OFF: irq_mask_q <= (irq_mask_q & ~wmask[3:0]) | (w_data_q[3:0] & wmask[3:0]);
        default: ;
      endcase
    end
  end

  // ********************************
  // AXI4-Lite read path
  // ********************************
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case ({s_axi_araddr[7:2], 2'b00})
      lpm_pkg::OSC_CTRL_OFF: rd_word = osc_ctrl_q;
      lpm_pkg::PB_CTRL_OFF: rd_word = pb_ctrl_q;
      lpm_pkg::STOP_IDLE_OFF: rd_word[NP-1:0] = stop_idle_q;
      lpm_pkg::MODE_STAT_OFF: rd_word[1:0] = state_q;
      lpm_pkg::IRQ_STAT_OFF: rd_word[3:0] = irq_stat_q;
      lpm_pkg::IRQ_MASK_OFF: rd_word[3:0] = irq_mask_q;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= lpm_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? lpm_pkg::RESP_OKAY : lpm_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end else begin
      s_axi_arready <= !s_axi_rvalid;
    end
  end

endmodule

//--- design/lpm_pkg.sv
// Constants shared by the low-power mode controller and its bench.
// Assumes a 40 MHz system clock and a 32-bit AXI4-Lite register bus.
package lpm_pkg;

  // ********************************
  // Register map
  // ********************************
  localparam logic [7:0] OSC_CTRL_OFF = 8'h00;
  localparam logic [7:0] PB_CTRL_OFF = 8'h04;
  localparam logic [7:0] STOP_IDLE_OFF = 8'h08;
  localparam logic [7:0] MODE_STAT_OFF = 8'h0C;
  localparam logic [7:0] IRQ_STAT_OFF = 8'h10;
  localparam logic [7:0] IRQ_MASK_OFF = 8'h14;

  // ********************************
  // Fields and reset values
  // ********************************
  localparam int CLK_SRC_LSB = 0;
  localparam int FAIL_MON_BIT = 2;
  localparam int WDOG_EN_BIT = 3;
  localparam int SLEEP_SEL_BIT = 4;
  localparam int CPU_DIV_LSB = 5;
  localparam int PB_DIV_W = 3;
  localparam int PB_EN_BIT = 3;
  localparam int EV_SLEEP = 0;
  localparam int EV_IDLE = 1;
  localparam int EV_RUN = 2;
  localparam int EV_WDOG = 3;
  localparam int EV_N = 4;
  localparam logic [31:0] OSC_CTRL_RST = 32'h0000_0004;
  localparam logic [31:0] PB_CTRL_RST = 32'h8888_8888;
  localparam logic [31:0] STOP_IDLE_RST = 32'h0000_0000;
  localparam logic [3:0] IRQ_MASK_RST = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ********************************
  // Clock sources and wake-up delays
  // ********************************
  localparam logic [1:0] SRC_FRC = 2'b00;
  localparam logic [1:0] SRC_POSC = 2'b01;
  localparam logic [1:0] SRC_SOSC = 2'b10;
  localparam logic [1:0] SRC_SLOW_RC = 2'b11;
  localparam int CLK_PERIOD_NS = 25;
  localparam int WAKE_FRC_NS = 250;
  localparam int WAKE_POSC_NS = 2000;
  localparam int WAKE_SOSC_NS = 10000;
  localparam int WAKE_SLOW_RC_NS = 5000;
  localparam int WAKE_FRC_CYC = (WAKE_FRC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_POSC_CYC = (WAKE_POSC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_SOSC_CYC = (WAKE_SOSC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_SLOW_RC_CYC = (WAKE_SLOW_RC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Gray order along run, sleep, wake-up, idle and back to run.
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_SLEEP = 2'b01,
    ST_WAKE = 2'b11,
    ST_IDLE = 2'b10
  } pwr_state_e;

endpackage

//--- tb/cpu_int_model.sv
// CPU core and interrupt controller as seen by the mode controller.
// Assumes bench commands are one-cycle pulses on aclk.
`timescale 1ns/10ps
module cpu_int_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bench commands
  input wire logic cmd_wait,
  input wire logic cmd_event,
  // Block side
  input wire logic cpu_halt,
  output logic wait_req,
  output logic int_req
);
  logic halt_q;
  // A halted core cannot execute the halt instruction again.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wait_req <= 1'b0;
    end else begin
      wait_req <= cmd_wait && !cpu_halt;
    end
  end
  // The flag stays pending until the core resumes from a halt.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_req <= 1'b0;
      halt_q <= 1'b0;
    end else begin
      halt_q <= cpu_halt;
      if (cmd_event) begin
        int_req <= 1'b1;
      end else if (halt_q && !cpu_halt) begin
        int_req <= 1'b0;
      end
    end
  end
endmodule

//--- tb/low_power_mode_control_monitor.sv
// Concurrent checks on the power mode controller's mode ports.
// Assumes one clock domain on aclk with a synchronous active-low reset.
`timescale 1ns/10ps
module low_power_mode_control_monitor #(
  parameter int PRIO_W = 3
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Mode inputs
  input wire logic wait_req,
  input wire logic [PRIO_W-1:0] cpu_prio,
  input wire logic int_req,
  input wire logic [PRIO_W-1:0] int_prio,
  input wire logic dev_reset_req,
  input wire logic watchdog_timeout,
  // Mode outputs
  input wire logic cpu_halt,
  input wire logic sys_clk_en,
  input wire logic clock_fail_monitor,
  input wire logic brownout_reset
);
  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic idle;
  logic woke_q;
  // Idle is the only halted state in which the system clock still runs.
  assign idle = cpu_halt && sys_clk_en;
  // Once a wake-up may have begun, a later watchdog pulse only meets a running count.
  always_ff @(posedge aclk) begin
    if (!aresetn || sys_clk_en) begin
      woke_q <= 1'b0;
    end else if (watchdog_timeout || (int_req && int_prio > cpu_prio)) begin
      woke_q <= 1'b1;
    end
  end
  a_sleep_halts: assert property (!sys_clk_en |-> cpu_halt)
    else $error("clock stopped while cpu runs");
  a_monitor_off: assert property (!sys_clk_en |-> !clock_fail_monitor)
    else $error("fail monitor on while clock stopped");
  a_brownout_on: assert property ($past(aresetn) |-> brownout_reset)
    else $error("brownout detector off");
  a_wait_halts: assert property (wait_req && !cpu_halt && !dev_reset_req |=> cpu_halt)
    else $error("wait did not halt cpu");
  a_idle_stays: assert property (idle && int_req && int_prio <= cpu_prio
    && !dev_reset_req && !watchdog_timeout |=> idle)
    else $error("idle left on low priority");
  a_idle_exits: assert property (idle && (dev_reset_req || watchdog_timeout
    || (int_req && int_prio > cpu_prio)) |=> !cpu_halt)
    else $error("idle not left");
  a_sleep_reset: assert property (!sys_clk_en && dev_reset_req |=> !cpu_halt && sys_clk_en)
    else $error("reset did not end sleep");
  a_wake_delay: assert property (!sys_clk_en && !woke_q && watchdog_timeout
    && !dev_reset_req |=> !sys_clk_en [*8])
    else $error("wake-up delay too short");
endmodule
bind low_power_mode_control low_power_mode_control_monitor #(.PRIO_W(PRIO_W)) u_monitor (
  .aclk, .aresetn, .wait_req, .cpu_prio, .int_req, .int_prio, .dev_reset_req,
  .watchdog_timeout, .cpu_halt, .sys_clk_en, .clock_fail_monitor, .brownout_reset
);

//--- tb/low_power_mode_control_tb.sv
// Self-checking bench for the power mode controller.
// Assumes lpm_pkg, the partner model and the checker are compiled first.
`timescale 1ns/10ps
module low_power_mode_control_tb;
  logic aclk, aresetn, wait_req, int_req, int_sleep_src, dev_reset_req, watchdog_timeout;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, cmd_wait, cmd_event;
  logic [7:0] s_axi_awaddr, s_axi_araddr, peripheral_bus_clock, periph_run;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp, clk_src;
  logic [2:0] cpu_prio, int_prio, cpu_clk_div;
  logic cpu_halt, sys_clk_en, clock_fail_monitor, brownout_reset, watchdog, irq;
  int n_errors, n_compared;
  low_power_mode_control u_low_power_mode_control (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .wait_req, .cpu_prio, .int_req, .int_prio,
    .int_sleep_src, .dev_reset_req, .watchdog_timeout, .cpu_halt, .sys_clk_en, .clk_src,
    .cpu_clk_div, .peripheral_bus_clock, .periph_run, .clock_fail_monitor, .brownout_reset,
    .watchdog, .irq);
  cpu_int_model u_cpu_int_model (.aclk, .aresetn, .cmd_wait, .cmd_event, .cpu_halt, .wait_req,
    .int_req);
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  task tally_and_finish;
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
      n_errors++;
    end
  endtask
  task step(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask
  task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("write response", er, s_axi_bresp);
  endtask
  task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task chk_rd(input string what, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    chk(what, e, d);
  endtask
  // Commands 0 and 1 pass through the partner and so land one edge later.
  task kick(input int k);
    @(posedge aclk);
    cmd_wait <= (k == 0);
    cmd_event <= (k == 1);
    watchdog_timeout <= (k == 2);
    dev_reset_req <= (k == 3);
    @(posedge aclk);
    cmd_wait <= 1'b0;
    cmd_event <= 1'b0;
    watchdog_timeout <= 1'b0;
    dev_reset_req <= 1'b0;
    if (k < 2) @(posedge aclk);
    #1;
  endtask
  task t_regs;
    logic [31:0] d;
    logic [1:0] r;
    chk_rd("osc reset", lpm_pkg::OSC_CTRL_OFF, lpm_pkg::OSC_CTRL_RST);
    chk_rd("bus reset", lpm_pkg::PB_CTRL_OFF, lpm_pkg::PB_CTRL_RST);
    chk_rd("stop reset", lpm_pkg::STOP_IDLE_OFF, lpm_pkg::STOP_IDLE_RST);
    chk_rd("mask reset", lpm_pkg::IRQ_MASK_OFF, {28'h0, lpm_pkg::IRQ_MASK_RST});
    axi_wr(lpm_pkg::MODE_STAT_OFF, 32'h0000_0003, lpm_pkg::RESP_OKAY);
    chk_rd("mode", lpm_pkg::MODE_STAT_OFF, 32'h0000_0000);
    axi_wr(8'h18, 32'hFFFF_FFFF, lpm_pkg::RESP_SLVERR);
    axi_rd(8'h18, d, r);
    chk("unmapped read", lpm_pkg::RESP_SLVERR, r);
  endtask
  task t_idle;
    axi_wr(lpm_pkg::STOP_IDLE_OFF, 32'h0000_0005, lpm_pkg::RESP_OKAY);
    axi_wr(lpm_pkg::IRQ_MASK_OFF, 32'h0000_0002, lpm_pkg::RESP_OKAY);
    @(posedge aclk);
    cpu_prio <= 3'h4;
    int_prio <= 3'h4;
    kick(0);
    chk("idle halt", 2'b11, {cpu_halt, sys_clk_en});
    chk("idle run mask", 8'hFA, periph_run);
    chk("idle bus clocks", 8'hFF, peripheral_bus_clock);
    kick(1);
    chk("equal priority", 1'b1, cpu_halt);
    step(2);
    chk("irq", 1'b1, irq);
    @(posedge aclk);
    int_prio <= 3'h5;
    step(1);
    chk("idle exit", 9'h0FF, {cpu_halt, periph_run});
    chk_rd("status", lpm_pkg::IRQ_STAT_OFF, 32'h0000_0006);
    axi_wr(lpm_pkg::IRQ_STAT_OFF, 32'h0000_000F, lpm_pkg::RESP_OKAY);
    chk_rd("status cleared", lpm_pkg::IRQ_STAT_OFF, 32'h0000_0000);
    step(2);
    chk("irq cleared", 1'b0, irq);
  endtask
  task t_sleep;
    axi_wr(lpm_pkg::OSC_CTRL_OFF, 32'h0000_001C, lpm_pkg::RESP_OKAY);
    @(posedge aclk);
    int_prio <= 3'h2;
    int_sleep_src <= 1'b1;
    kick(0);
    chk("sleep halt", 2'b10, {cpu_halt, sys_clk_en});
    chk("sleep monitors", 3'b011, {clock_fail_monitor, brownout_reset, watchdog});
    chk("sleep bus clocks", 8'h00, peripheral_bus_clock);
    chk("sleep run mask", 8'hF0, periph_run);
    kick(1);
    chk_rd("low priority wake", lpm_pkg::MODE_STAT_OFF, 32'h0000_0002);
    @(posedge aclk);
    int_prio <= 3'h5;
    step(1);
    chk("run again", 2'b01, {cpu_halt, clock_fail_monitor});
    kick(0);
    kick(3);
    chk("reset exit", 2'b01, {cpu_halt, sys_clk_en});
    kick(0);
    kick(2);
    chk_rd("watchdog exit", lpm_pkg::MODE_STAT_OFF, 32'h0000_0003);
    step(20);
    axi_wr(lpm_pkg::OSC_CTRL_OFF, 32'h0000_000C, lpm_pkg::RESP_OKAY);
    kick(0);
    kick(2);
    chk("idle watchdog exit", 1'b0, cpu_halt);
    chk_rd("sleep events", lpm_pkg::IRQ_STAT_OFF, 32'h0000_000F);
  endtask
  task t_wake;
    int e, n;
    for (int s = 0; s < 4; s++) begin
      e = s == 0 ? lpm_pkg::WAKE_FRC_CYC : s == 1 ? lpm_pkg::WAKE_POSC_CYC :
        s == 2 ? lpm_pkg::WAKE_SOSC_CYC : lpm_pkg::WAKE_SLOW_RC_CYC;
      axi_wr(lpm_pkg::OSC_CTRL_OFF, 32'h0000_0010 + 32'(s), lpm_pkg::RESP_OKAY);
      @(posedge aclk);
      int_sleep_src <= 1'b0;
      kick(0);
      kick(1);
      chk("source not in sleep", 1'b0, sys_clk_en);
      @(posedge aclk);
      int_sleep_src <= 1'b1;
      step(1);
      n = 0;
      while (cpu_halt === 1'b1 && n < 1000) begin
        step(1);
        n++;
      end
      chk("wake delay", 32'(e), 32'(n));
    end
  endtask
  task t_clocks;
    int n, m;
    chk("bus clocks", 8'hFF, peripheral_bus_clock);
    axi_wr(lpm_pkg::OSC_CTRL_OFF, 32'h0000_00E3, lpm_pkg::RESP_OKAY);
    step(2);
    chk("cpu clock", 5'h1F, {clk_src, cpu_clk_div});
    axi_wr(lpm_pkg::PB_CTRL_OFF, 32'h0000_000A, lpm_pkg::RESP_OKAY);
    n = 0;
    m = 0;
    repeat (64) begin
      step(1);
      n += peripheral_bus_clock[0];
      m += peripheral_bus_clock[7:1];
    end
    chk("bus 0 pulses", 32'd16, n);
    chk("stopped buses", 32'd0, m);
  endtask
  initial begin
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, cpu_prio, int_prio} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {cmd_wait, cmd_event, int_sleep_src, dev_reset_req, watchdog_timeout} = '0;
    n_errors = 0;
    n_compared = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_idle;
    t_sleep;
    t_wake;
    t_clocks;
    tally_and_finish;
  end
  // The slowest wake-up takes some 400 cycles; the whole run needs far less than this.
  initial begin
    repeat (8000) @(posedge aclk);
    n_errors++;
    tally_and_finish;
  end
endmodule
